// File: src/ref_edge_detect.sv
// Two-stage synchroniser and polarity-selected edge detector for one reference input
`timescale 1ns/1ps
module ref_edge_detect
   import trim_ref_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Reference
   input wire logic raw_in,
   input wire logic falling_sel,
   // Edge event
   output logic edge_pulse
);
   typedef struct packed {
      logic stage1;
      logic stage2;
      logic last;
   } edge_state_type;

   edge_state_type state_reg;
   edge_state_type state_next;

   always_comb begin
      state_next = state_reg;
      state_next.stage1 = raw_in;
      state_next.stage2 = state_reg.stage1;
      state_next.last = state_reg.stage2;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Polarity picks which transition counts as an edge
   assign edge_pulse = (state_reg.stage2 != state_reg.last) && (state_reg.stage2 == !falling_sel);

   chk_edge_polarity: assert property (@(posedge clk) disable iff (sys_rst)
      edge_pulse |-> (falling_sel ? $fell(state_reg.stage2) : $rose(state_reg.stage2)))
      else $error("edge pulse does not match selected polarity");
endmodule

// File: src/ref_prescaler.sv
// Power-of-two divider of reference edges into single-cycle sync pulses
`timescale 1ns/1ps
module ref_prescaler
   import trim_ref_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Control
   input wire logic run,
   input wire logic [2:0] divider,
   // Edges in, sync pulses out
   input wire logic edge_in,
   output logic sync_pulse
);
   typedef struct packed {
      logic [6:0] count;
   } div_state_type;

   div_state_type state_reg;
   div_state_type state_next;
   logic [6:0] mask;

   assign mask = 7'(({1'b0, 7'h7F} >> (3'h7 - divider)));
   assign sync_pulse = run && edge_in && (state_reg.count == mask);

   always_comb begin
      state_next = state_reg;
      if (!run) begin
         state_next.count = '0;
      end else if (edge_in) begin
         state_next.count = sync_pulse ? 7'h00 : 7'(state_reg.count + 7'h01);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   chk_prescale_undivided: assert property (@(posedge clk) disable iff (sys_rst)
      (run && divider == 3'h0 && edge_in) |-> sync_pulse)
      else $error("undivided reference dropped an edge");

   chk_prescale_full: assert property (@(posedge clk) disable iff (sys_rst)
      (sync_pulse && divider == 3'h7) |-> state_reg.count == 7'h7F)
      else $error("divide by 128 fired early");
endmodule

// File: src/trim_ref_pkg.sv
// Constants shared by the reference configuration and capture path
package trim_ref_pkg;
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] CONFIG_OFFSET = 4'h4;
   localparam logic [3:0] STATUS_OFFSET = 4'h8;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int POLARITY_BIT = 31;
   localparam int SOURCE_HI = 29;
   localparam int SOURCE_LO = 28;
   localparam int DIVIDER_HI = 26;
   localparam int DIVIDER_LO = 24;
   localparam int LIMIT_HI = 23;
   localparam int LIMIT_LO = 16;
   localparam int RELOAD_HI = 15;
   localparam int RELOAD_LO = 0;
   localparam int CAPTURE_HI = 31;
   localparam int CAPTURE_LO = 16;
   localparam int DIRECTION_BIT = 15;
   localparam logic [31:0] CONFIG_RESET = 32'h2022BB7F;
   localparam logic [31:0] CONFIG_WRITABLE = 32'hB7FFFFFF;
   localparam logic [1:0] SOURCE_PIN = 2'h0;
   localparam logic [1:0] SOURCE_CRYSTAL = 2'h1;
   localparam logic [3:0] FULL_WORD = 4'hF;
   localparam logic DIR_UP = 1'b0;
   localparam logic DIR_DOWN = 1'b1;
   localparam int WARN_LOW_FACTOR = 3;
   localparam int WARN_HIGH_SHIFT = 7;
endpackage

// File: src/trim_reference_config.sv
// Reference configuration registers, trim counter and sync capture
//
// Overview of operation
// - Configuration writes are ignored while the trim counter is enabled.
// - Polarity bit 31 picks rising (0) or falling (1) reference edges.
// - Source field 29:28 picks pin (00) or crystal (01); others reserved.
// - Divider field 26:24 divides the reference by two to its value.
// - Base limit 23:16 is software read/write and feeds the classification logic.
// - Each sync pulse loads the reload value 15:0 into the trim counter.
// - Status bits 31:16 show the captured counter value.
// - Configuration reads back 0x2022BB7F after reset.
// - Each sync pulse copies the trim counter into the captured value.
// - A sync pulse while counting captures direction into status bit 15.
// - Count between three and 128 times the limit at a sync pulse, except the first after enable, flags a correctable warning.
`timescale 1ns/1ps
module trim_reference_config
   import trim_ref_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Reference inputs
   input wire logic external_sync_input,
   input wire logic low_speed_crystal_clock,
   // Towards the classification and trim logic
   output logic trim_counter_enable,
   output logic [7:0] trim_base_limit,
   output logic [15:0] counter_capture_value,
   output logic captured_count_direction,
   output logic reference_sync_pulse,
   output logic trim_warning
);
   typedef struct packed {
      logic enable;
      logic [31:0] config_word;
      logic [15:0] count;
      logic direction;
      logic [15:0] capture;
      logic capture_dir;
      logic warning;
      logic sync_seen;
      logic ack;
      logic [31:0] rdata;
   } main_state_type;

   main_state_type state_reg;
   main_state_type state_next;

   logic pin_edge;
   logic crystal_edge;
   logic selected_edge;
   logic sync_pulse;
   logic [1:0] source;
   logic [15:0] reload;
   logic [15:0] limit_x128;
   logic [15:0] limit_x3;
   logic request;
   logic accept;
   logic cfg_write_ok;
   logic warn_cond;
   logic [31:0] status_word;

   assign source = state_reg.config_word[SOURCE_HI:SOURCE_LO];
   assign reload = state_reg.config_word[RELOAD_HI:RELOAD_LO];
   assign trim_base_limit = state_reg.config_word[LIMIT_HI:LIMIT_LO];
   assign limit_x128 = 16'({trim_base_limit, 7'h00} >> (7 - WARN_HIGH_SHIFT));
   assign limit_x3 = 16'(trim_base_limit * WARN_LOW_FACTOR);

   // Both references are synchronised and polarity-checked before the divider
   ref_edge_detect pin_detect (
      .clk(clk),
      .sys_rst(sys_rst),
      .raw_in(external_sync_input),
      .falling_sel(state_reg.config_word[POLARITY_BIT]),
      .edge_pulse(pin_edge)
   );

   ref_edge_detect crystal_detect (
      .clk(clk),
      .sys_rst(sys_rst),
      .raw_in(low_speed_crystal_clock),
      .falling_sel(state_reg.config_word[POLARITY_BIT]),
      .edge_pulse(crystal_edge)
   );

   always_comb begin
      case (source)
         SOURCE_PIN: selected_edge = pin_edge;
         SOURCE_CRYSTAL: selected_edge = crystal_edge;
         default: selected_edge = 1'b0;
      endcase
   end

   ref_prescaler divider (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(state_reg.enable),
      .divider(state_reg.config_word[DIVIDER_HI:DIVIDER_LO]),
      .edge_in(selected_edge),
      .sync_pulse(sync_pulse)
   );

   // One wait state per access; the answer comes on the second cycle
   assign request = avs_read || avs_write;
   assign avs_waitrequest = request && !state_reg.ack;
   assign accept = request && state_reg.ack;
   assign cfg_write_ok = accept && avs_write && avs_address == CONFIG_OFFSET
      && avs_byteenable == FULL_WORD && !state_reg.enable;
   assign warn_cond = (state_reg.count >= limit_x3) && (state_reg.count < limit_x128);

   assign status_word = {state_reg.capture, state_reg.capture_dir, 15'h0000};

   always_comb begin
      state_next = state_reg;
      state_next.ack = request && !state_reg.ack;
      state_next.warning = 1'b0;
      if (request && !state_reg.ack) begin
         case (avs_address)
            CTRL_OFFSET: state_next.rdata = {31'h00000000, state_reg.enable};
            CONFIG_OFFSET: state_next.rdata = state_reg.config_word;
            STATUS_OFFSET: state_next.rdata = status_word;
            default: state_next.rdata = 32'h00000000;
         endcase
      end
      if (accept && avs_write && avs_address == CTRL_OFFSET && avs_byteenable[0]) begin
         state_next.enable = avs_writedata[CTRL_ENABLE_BIT];
      end
      if (cfg_write_ok) begin
         // Reserved bits keep their reset value
         state_next.config_word = (avs_writedata & CONFIG_WRITABLE) | (CONFIG_RESET & ~CONFIG_WRITABLE);
      end
      if (!state_reg.enable) begin
         state_next.sync_seen = 1'b0;
      end else if (sync_pulse) begin
         state_next.count = reload;
         state_next.direction = DIR_DOWN;
         state_next.sync_seen = 1'b1;
         state_next.capture = state_reg.count;
         state_next.capture_dir = state_reg.direction;
         state_next.warning = state_reg.sync_seen && warn_cond;
      end else if (state_reg.sync_seen) begin
         if (state_reg.direction == DIR_DOWN) begin
            if (state_reg.count == 16'h0000) begin
               state_next.direction = DIR_UP;
               state_next.count = 16'h0001;
            end else begin
               state_next.count = 16'(state_reg.count - 16'h0001);
            end
         end else if (state_reg.count < limit_x128) begin
            // Up-counting stops at 128 times the limit
            state_next.count = 16'(state_reg.count + 16'h0001);
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg.enable <= 1'b0;
         state_reg.config_word <= CONFIG_RESET;
         state_reg.count <= 16'h0000;
         state_reg.direction <= DIR_UP;
         state_reg.capture <= 16'h0000;
         state_reg.capture_dir <= DIR_UP;
         state_reg.warning <= 1'b0;
         state_reg.sync_seen <= 1'b0;
         state_reg.ack <= 1'b0;
         state_reg.rdata <= 32'h00000000;
      end else begin
         state_reg <= state_next;
      end
   end

   assign avs_readdata = state_reg.rdata;
   assign trim_counter_enable = state_reg.enable;
   assign counter_capture_value = state_reg.capture;
   assign captured_count_direction = state_reg.capture_dir;
   assign reference_sync_pulse = sync_pulse && state_reg.enable;
   assign trim_warning = state_reg.warning;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   chk_config_locked: assert property (
      (accept && avs_write && avs_address == CONFIG_OFFSET && state_reg.enable) |=> $stable(state_reg.config_word))
      else $error("configuration changed while counter enabled");

   chk_partial_dropped: assert property (
      (accept && avs_write && avs_byteenable != FULL_WORD && !cfg_write_ok)
      |=> $stable(state_reg.config_word))
      else $error("partial write altered configuration");

   chk_source_reserved: assert property (
      selected_edge |-> !source[1])
      else $error("reserved source produced an edge");

   chk_reload_load: assert property (
      (sync_pulse && state_reg.enable) |=> state_reg.count == $past(reload))
      else $error("sync pulse did not load reload value");

   chk_capture_value: assert property (
      (sync_pulse && state_reg.enable) |=> counter_capture_value == $past(state_reg.count))
      else $error("captured value wrong");

   chk_capture_dir: assert property (
      (sync_pulse && state_reg.enable) |=> captured_count_direction == $past(state_reg.direction))
      else $error("captured direction wrong");

   chk_warning_class: assert property (
      (sync_pulse && state_reg.enable && state_reg.sync_seen) |=> trim_warning == $past(warn_cond))
      else $error("warning classification wrong");

   chk_reserved_zero: assert property (
      !state_reg.config_word[30] && !state_reg.config_word[27])
      else $error("reserved configuration bit set");

   chk_bus_answer: assert property (
      (request && avs_waitrequest) |=> (!request || !avs_waitrequest))
      else $error("bus answer later than one wait state");

   // Register bus writes and reads
   chk_config_update: assert property (
      cfg_write_ok |=> state_reg.config_word[RELOAD_HI:RELOAD_LO] == $past(avs_writedata[RELOAD_HI:RELOAD_LO]))
      else $error("accepted configuration write did not land");

   chk_limit_write: assert property (
      cfg_write_ok |=> trim_base_limit == $past(avs_writedata[LIMIT_HI:LIMIT_LO]))
      else $error("base limit write did not land");

   chk_ctrl_write: assert property (
      (accept && avs_write && avs_address == CTRL_OFFSET && avs_byteenable[0])
      |=> trim_counter_enable == $past(avs_writedata[CTRL_ENABLE_BIT]))
      else $error("enable write did not land");

   chk_config_read: assert property (
      (accept && avs_read && avs_address == CONFIG_OFFSET) |-> avs_readdata == $past(state_reg.config_word))
      else $error("configuration read data wrong");

   chk_status_read: assert property (
      (accept && avs_read && avs_address == STATUS_OFFSET) |-> avs_readdata == $past(status_word))
      else $error("status read data wrong");

   chk_unmapped_read: assert property (
      (accept && avs_read && avs_address != CTRL_OFFSET && avs_address != CONFIG_OFFSET
      && avs_address != STATUS_OFFSET) |-> avs_readdata == 32'h00000000)
      else $error("unmapped read returned data");

   chk_rdata_hold: assert property (
      !request |=> $stable(avs_readdata))
      else $error("read data changed without a request");

   chk_wait_first: assert property (
      (request && !$past(request)) |-> avs_waitrequest)
      else $error("new request answered without a wait state");

   // Reference path gating
   chk_sync_needs_enable: assert property (
      sync_pulse |-> state_reg.enable)
      else $error("sync pulse while counter disabled");

   chk_reserved_quiet: assert property (
      source[1] |-> !reference_sync_pulse)
      else $error("sync pulse from reserved source");

   // Trim counter sequence
   chk_direction_load: assert property (
      (sync_pulse && state_reg.enable) |=> state_reg.direction == DIR_DOWN)
      else $error("sync pulse did not start down-counting");

   chk_count_down: assert property (
      (state_reg.enable && state_reg.sync_seen && !sync_pulse && state_reg.direction == DIR_DOWN
      && state_reg.count != 16'h0000) |=> state_reg.count == 16'($past(state_reg.count) - 16'h0001))
      else $error("down-count step wrong");

   chk_count_turn: assert property (
      (state_reg.enable && state_reg.sync_seen && !sync_pulse && state_reg.direction == DIR_DOWN
      && state_reg.count == 16'h0000) |=> state_reg.direction == DIR_UP && state_reg.count == 16'h0001)
      else $error("counter did not turn at zero");

   chk_count_ceiling: assert property (
      (state_reg.sync_seen && state_reg.direction == DIR_UP && trim_base_limit != 8'h00)
      |-> state_reg.count <= limit_x128)
      else $error("up-count passed 128 times the limit");

   chk_count_idle: assert property (
      !state_reg.enable |=> $stable(state_reg.count))
      else $error("counter moved while disabled");

   chk_disable_clears: assert property (
      !state_reg.enable |=> !state_reg.sync_seen)
      else $error("running state kept while disabled");

   // Warning pulse timing
   chk_warning_after_sync: assert property (
      trim_warning |-> $past(reference_sync_pulse))
      else $error("warning without a preceding sync pulse");

   chk_first_quiet: assert property (
      (sync_pulse && state_reg.enable && !state_reg.sync_seen) |=> !trim_warning)
      else $error("first sync after enable raised a warning");
endmodule

// File: tb/ref_source_model.sv
// Reference source model: pulsed external sync pin and free-running crystal
`timescale 1ns/1ps
module ref_source_model (
   // Clock
   input wire logic clk,
   // Waveform shape in clock cycles
   input wire logic [15:0] pin_period,
   input wire logic [15:0] pin_high,
   input wire logic [15:0] xtal_half,
   // Reference lines
   output logic external_sync_input,
   output logic low_speed_crystal_clock,
   output logic [15:0] pin_phase
);
   logic [15:0] xtal_count = 16'h0000;
   logic [15:0] phase_reg = 16'h0000;
   logic pin_reg = 1'b0;
   logic xtal_reg = 1'b0;
   assign external_sync_input = pin_reg;
   assign low_speed_crystal_clock = xtal_reg;
   assign pin_phase = phase_reg;
   // Pin is high for the first pin_high cycles of each period; crystal runs free
   always @(posedge clk) begin
      phase_reg <= (phase_reg + 16'h0001) % pin_period;
      pin_reg <= (phase_reg < pin_high);
      xtal_count <= (xtal_count + 16'h0001) % xtal_half;
      if (xtal_count == xtal_half - 16'h0001) begin
         xtal_reg <= !xtal_reg;
      end
   end
endmodule

// File: tb/trim_reference_config_test.sv
// Self-checking testbench for the reference configuration and capture path
`timescale 1ns/1ps
module trim_reference_config_test
   import trim_ref_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata, cfg_m, q, c;
   logic avs_waitrequest, external_sync_input, low_speed_crystal_clock, trim_counter_enable;
   logic captured_count_direction, reference_sync_pulse, trim_warning, exp_dir, en_m = 1'b0, pend = 1'b0;
   logic [7:0] trim_base_limit;
   logic [15:0] counter_capture_value, pin_phase;
   int n_errors = 0, samples_checked = 0, seed = 246, cyc = 0, last = -1, n_sync = 0;
   int want_gap = 40, want_phase = -1, rl = 0, lim = 1, exp_cap = 0;
   int pols[5] = '{0, 1, 0, 0, 0};
   int srcs[5] = '{0, 0, 1, 0, 2};
   int divs[5] = '{0, 0, 1, 2, 0};

   always #2 clk = ~clk;

   trim_reference_config DUT (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .external_sync_input(external_sync_input),
      .low_speed_crystal_clock(low_speed_crystal_clock), .trim_counter_enable(trim_counter_enable),
      .trim_base_limit(trim_base_limit), .counter_capture_value(counter_capture_value),
      .captured_count_direction(captured_count_direction), .reference_sync_pulse(reference_sync_pulse),
      .trim_warning(trim_warning));
   ref_source_model source (.clk(clk), .pin_period(16'h0028), .pin_high(16'h000A), .xtal_half(16'h0019),
      .external_sync_input(external_sync_input), .low_speed_crystal_clock(low_speed_crystal_clock),
      .pin_phase(pin_phase));

   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One Avalon transfer; the bench model of the registers follows accepted writes
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         n_errors++;
         end_of_test();
      end
      q = avs_readdata;
      if (wr && a == CONFIG_OFFSET && be == FULL_WORD && !en_m) cfg_m = d & CONFIG_WRITABLE;
      if (wr && a == CTRL_OFFSET && be[0]) en_m = d[0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   // Sync monitor: period, phase, and capture predicted from the reload and elapsed cycles
   always @(posedge clk) begin
      cyc++;
      if (pend) begin
         check("capture", counter_capture_value, exp_cap[15:0]);
         check("direction", captured_count_direction, exp_dir);
         check("warning", trim_warning, exp_cap >= 3 * lim && exp_cap < 128 * lim);
      end else if (trim_warning !== 1'b0) begin
         check("warning", trim_warning, 1'b0);
      end
      pend = 1'b0;
      if (reference_sync_pulse === 1'b1) begin
         n_sync++;
         if (want_phase >= 0) check("phase", pin_phase, want_phase);
         if (last >= 0) begin
            check("period", cyc - last, want_gap);
            exp_dir = rl > cyc - last - 1;
            exp_cap = exp_dir ? rl - (cyc - last - 1) : (cyc - last - 1) - rl;
            pend = 1'b1;
         end
         last = cyc;
      end
   end

   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      cfg_m = CONFIG_RESET;
      bus(1'b0, CONFIG_OFFSET, 32'h00000000, 4'hF);
      check("config", q, cfg_m);
      bus(1'b0, STATUS_OFFSET, 32'h00000000, 4'hF);
      check("status", q, 32'h00000000);
      bus(1'b0, 4'hC, 32'h00000000, 4'hF);
      check("unmapped", q, 32'h00000000);
      check("limit", trim_base_limit, 8'h22);
      for (int k = 0; k < 5; k++) begin
         bus(1'b1, CTRL_OFFSET, 32'h00000000, 4'hF);
         lim = 1 + {$random(seed)} % 8;
         want_gap = (srcs[k] == 1 ? 50 : 40) << divs[k];
         rl = want_gap - 1 + $random(seed) % 30;
         if (rl == want_gap - 1) rl++;
         c = {pols[k][0], 1'b0, srcs[k][1:0], 1'b0, divs[k][2:0], lim[7:0], rl[15:0]};
         bus(1'b1, CONFIG_OFFSET, c ^ 32'h00FFFFFF, 4'h3);
         bus(1'b1, CONFIG_OFFSET, c, 4'hF);
         bus(1'b0, CONFIG_OFFSET, 32'h00000000, 4'hF);
         check("config", q, cfg_m);
         check("limit", trim_base_limit, lim[7:0]);
         last = -1;
         n_sync = 0;
         want_phase = (srcs[k] == 0 && divs[k] == 0) ? 3 + pols[k] * 10 : -1;
         bus(1'b1, CTRL_OFFSET, 32'h00000001, 4'hF);
         check("enable", trim_counter_enable, en_m);
         bus(1'b1, CONFIG_OFFSET, c ^ 32'h00FFFFFF, 4'hF);
         bus(1'b0, CONFIG_OFFSET, 32'h00000000, 4'hF);
         check("config locked", q, cfg_m);
         for (int w = 0; w < 3000 && n_sync < 4; w++) @(posedge clk);
         check("sync seen", n_sync >= 4, srcs[k] < 2);
         bus(1'b1, CTRL_OFFSET, 32'h00000000, 4'hF);
         bus(1'b0, STATUS_OFFSET, 32'h00000000, 4'hF);
         if (srcs[k] < 2) check("status", q[31:15], {exp_cap[15:0], exp_dir});
      end
      end_of_test();
   end
endmodule
